// file: logic/rbs_defines.svh
// Offsets, field positions, reset values and timing counts of the bind and status sequencer
`ifndef RBS_DEFINES_SVH
`define RBS_DEFINES_SVH
// Clock and base tick
`define RBS_CLK_MHZ 125
`define RBS_TICK_US 1000
`define RBS_TICK_CYC (`RBS_TICK_US * `RBS_CLK_MHZ)
// Register byte offsets and reset values
`define RBS_CTRL_OFF 32'h0000_0000
`define RBS_STATUS_OFF 32'h0000_0004
`define RBS_NODE_ID_OFF 32'h0000_0008
`define RBS_DROP_OFF 32'h0000_000C
`define RBS_CTRL_RST 16'h0000
`define RBS_NODE_ID_RST 8'h00
// Control field positions
`define RBS_CTRL_COORD 0
`define RBS_CTRL_SINGLE 1
`define RBS_CTRL_SER_DIS 2
`define RBS_CTRL_FRAME 3
`define RBS_CTRL_SLOT_LO 4
`define RBS_CTRL_SLOT_HI 5
`define RBS_CTRL_USER_LO 8
`define RBS_CTRL_USER_HI 15
// AXI responses
`define RBS_RESP_OKAY 2'h0
`define RBS_RESP_SLVERR 2'h2
// LED colour codes {green, red}
`define RBS_LED_OFF 2'h0
`define RBS_LED_RED 2'h1
`define RBS_LED_GRN 2'h2
`define RBS_LED_AMB 2'h3
// Indicator timing in ms ticks
`define RBS_AMBER_MS 13'h01F4
`define RBS_HOLD_MS 13'h0FA0
`define RBS_FAST_BIT 8
`define RBS_PKT_BIT 6
`define RBS_BOUND_FLASHES 4
`define RBS_FLASH_MS 13'h0800
`define RBS_RUN_SOLID_MS 13'h03E8
`define RBS_SLOW_PERIOD_MS 12'hBB8
`define RBS_SLOW_ON_MS 12'h0C8
`define RBS_PKT_MS 8'hC8
`define RBS_CLICK_GAP_MS 10'h190
// Slot budget and frame timing
`define RBS_SLOT_FRAME 8'h80
`define RBS_SLOT_32 8'h20
`define RBS_SLOT_4 8'h04
`define RBS_FRAME_OFF_MS 8'h3C
`define RBS_FRAME_ON_MS 8'h28
// Node ID ranges
`define RBS_LOCAL_ID_MAX 8'h0A
`define RBS_RADIO_ID_MIN 8'h0B
`define RBS_RADIO_ID_MAX 8'h3C
`endif

// file: logic/rbs_pkg.sv
// Types shared by the bind and status sequencer
package rbs_pkg;
  // Indicator sequence states
  typedef enum logic [3:0] {
    ST_POWERUP,
    ST_SEARCH,
    ST_DETECT,
    ST_CHOSEN,
    ST_SYNCING,
    ST_SYNCED,
    ST_RUN_SOLID,
    ST_RUN,
    ST_BIND,
    ST_BOUND_HOLD,
    ST_BOUND_FLASH
  } rbs_state_type;
endpackage : rbs_pkg

// file: logic/rbs_click_counter.sv
// Button click counter telling double from triple clicks
`timescale 1ns/1ps
`include "rbs_defines.svh"
module rbs_click_counter (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Press events and ms tick
  input wire logic press_i,
  input wire logic tick_i,
  // Click results, one-cycle pulses
  output logic dbl_o,
  output logic tri_o
);
  logic [2:0] cnt_r;   // Presses in current burst
  logic [9:0] gap_r;   // Ms left in gap window

  // Burst counting; the window restarts on every press
  always_ff @(posedge clk_i)
  begin
    dbl_o <= 1'b0;
    tri_o <= 1'b0;
    if (srst_i)
    begin
      cnt_r <= 3'h0;
      gap_r <= 10'h000;
    end
    else if (press_i)
    begin
      // Saturate so four or more presses give no event
      if (cnt_r != 3'h4)
        cnt_r <= cnt_r + 3'h1;
      gap_r <= `RBS_CLICK_GAP_MS;
    end
    else if (tick_i && gap_r != 10'h000)
    begin
      gap_r <= gap_r - 10'h001;
      if (gap_r == 10'h001)
      begin
        // Window closed: judge the burst
        dbl_o <= (cnt_r == 3'h2);
        tri_o <= (cnt_r == 3'h3);
        cnt_r <= 3'h0;
      end
    end
  end

  property p_click_excl;
    @(posedge clk_i) disable iff (srst_i)
    (tri_o || dbl_o) |-> !(tri_o && dbl_o) && cnt_r == 3'h0 && gap_r == 10'h000;
  endproperty
  a_click_excl: assert property (p_click_excl) else $error("click result not exclusive");
endmodule : rbs_click_counter

// file: logic/rbs_top.sv
// Bind, sync and LED status sequencer with AXI4-Lite control
`timescale 1ns/1ps
`include "rbs_defines.svh"
// Function
// - Serial disable leaves radio activity untouched
// - Child transmits only in budgeted slots
// - Frame selector gives 60 or 40 ms
// - Polls to local IDs never relayed
// - Coordinator triple click: binding, LEDs flash red, single LED red/green
// - Child triple click: binding, alternating red, single LED solid red
// - Bound: red solid 4 s, four flashes
// - Child leaves binding on binding code
// - Coordinator double click ends binding; forming follows
// - Sync only to synchronized parent
// - Child amber at power, then red search
// - Detected, chosen, syncing indications in order
// - Synced, run and packet indications
// - Coordinator amber, green run, packet amber
module rbs_top #(
  parameter int unsigned TICK_CYC = `RBS_TICK_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // AXI4-Lite slave
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Operator button pin
  input wire logic btn_i,
  // Network layer events, same clock
  input wire logic parent_seen_i,
  input wire logic parent_chosen_i,
  input wire logic parent_ready_i,
  input wire logic sync_done_i,
  input wire logic run_i,
  input wire logic pkt_i,
  input wire logic bind_code_i,
  input wire logic slot_tick_i,
  input wire logic poll_valid_i,
  input wire logic [7:0] poll_id_i,
  // Network layer controls
  output logic form_net_o,
  output logic sync_req_o,
  output logic tx_allow_o,
  output logic [7:0] frame_ms_o,
  output logic serial_en_o,
  output logic relay_valid_o,
  output logic [7:0] relay_id_o,
  // LEDs {green, red}
  output logic [1:0] led1_o,
  output logic [1:0] led2_o
);
  rbs_pkg::rbs_state_type state_r; // Sequence state
  logic [15:0] ctrl_r;             // Control register
  logic [7:0] node_id_r;           // Own radio ID
  logic [7:0] drop_cnt_r;          // Polls kept local
  logic [16:0] div_r;              // Tick divider
  logic tick_r;                    // One ms pulse
  logic [11:0] ms_r;               // Free ms phase counter
  logic [12:0] tmr_r;              // State timer in ms
  logic [7:0] pkt_r;               // Packet activity stretch
  logic [6:0] slot_r;              // Slot index in frame
  logic btn_s1_r;                  // Sync stage one
  logic btn_s2_r;                  // Sync stage two
  logic btn_ms_r;                  // Button sampled each ms
  logic press;                     // Debounced press edge
  logic dbl_click;                 // Double click pulse
  logic tri_click;                 // Triple click pulse
  logic aw_held_r;                 // Write address taken
  logic w_held_r;                  // Write data taken
  logic [31:0] awaddr_r;           // Held write address
  logic [31:0] wdata_r;            // Held write data
  logic [3:0] wstrb_r;             // Held strobes
  logic [7:0] budget;              // Slots allowed per frame
  logic [1:0] l1;                  // LED 1 pattern
  logic [1:0] l2;                  // LED 2 pattern
  logic fast;                      // Fast flash phase
  logic slow;                      // One per three seconds blip
  logic coord;                     // Coordinator role
  logic single;                    // Single LED unit

  assign coord = ctrl_r[`RBS_CTRL_COORD];
  assign single = ctrl_r[`RBS_CTRL_SINGLE];

  // Free ms divider feeding every flash rate
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      div_r <= 17'h00000;
      tick_r <= 1'b0;
      ms_r <= 12'h000;
    end
    else
    begin
      tick_r <= (div_r == 17'(TICK_CYC - 1));
      div_r <= (div_r == 17'(TICK_CYC - 1)) ? 17'h00000 : div_r + 17'h00001;
      if (tick_r)
        ms_r <= (ms_r == `RBS_SLOW_PERIOD_MS - 12'h001) ? 12'h000 : ms_r + 12'h001;
    end
  end

  assign fast = ms_r[`RBS_FAST_BIT];
  assign slow = (ms_r < `RBS_SLOW_ON_MS);

  // Button synchroniser; sampling once per ms also rides out contact bounce
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      btn_s1_r <= 1'b0;
      btn_s2_r <= 1'b0;
      btn_ms_r <= 1'b0;
    end
    else
    begin
      btn_s1_r <= btn_i;
      btn_s2_r <= btn_s1_r;
      if (tick_r)
        btn_ms_r <= btn_s2_r;
    end
  end

  assign press = tick_r && btn_s2_r && !btn_ms_r;

  rbs_click_counter u_click (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .press_i(press),
    .tick_i(tick_r),
    .dbl_o(dbl_click),
    .tri_o(tri_click)
  );

  // Sequence state machine and its timer
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      state_r <= rbs_pkg::ST_POWERUP;
      tmr_r <= `RBS_AMBER_MS;
    end
    else
    begin
      if (tick_r && tmr_r != 13'h0000)
        tmr_r <= tmr_r - 13'h0001;
      if (tri_click && state_r != rbs_pkg::ST_BIND && state_r != rbs_pkg::ST_BOUND_HOLD &&
          state_r != rbs_pkg::ST_BOUND_FLASH)
        state_r <= rbs_pkg::ST_BIND;
      else
        case (state_r)
          rbs_pkg::ST_POWERUP:
            // Coordinator goes straight to run after its amber phase
            if (tmr_r == 13'h0000)
              state_r <= coord ? rbs_pkg::ST_RUN : rbs_pkg::ST_SEARCH;
          rbs_pkg::ST_SEARCH:
            if (parent_seen_i)
              state_r <= rbs_pkg::ST_DETECT;
          rbs_pkg::ST_DETECT:
            if (parent_chosen_i)
              state_r <= rbs_pkg::ST_CHOSEN;
          rbs_pkg::ST_CHOSEN:
            // Wait until the chosen parent is itself in sync
            if (parent_ready_i)
              state_r <= rbs_pkg::ST_SYNCING;
          rbs_pkg::ST_SYNCING:
            if (sync_done_i)
              state_r <= rbs_pkg::ST_SYNCED;
          rbs_pkg::ST_SYNCED:
            if (run_i)
            begin
              state_r <= rbs_pkg::ST_RUN_SOLID;
              tmr_r <= `RBS_RUN_SOLID_MS;
            end
          rbs_pkg::ST_RUN_SOLID:
            if (tmr_r == 13'h0000)
              state_r <= rbs_pkg::ST_RUN;
          rbs_pkg::ST_BIND:
            // Coordinator leaves on double click, child on the binding code
            if (coord && dbl_click)
              state_r <= rbs_pkg::ST_RUN;
            else if (!coord && bind_code_i)
            begin
              state_r <= rbs_pkg::ST_BOUND_HOLD;
              tmr_r <= `RBS_HOLD_MS;
            end
          rbs_pkg::ST_BOUND_HOLD:
            if (tmr_r == 13'h0000)
            begin
              state_r <= rbs_pkg::ST_BOUND_FLASH;
              tmr_r <= `RBS_FLASH_MS;
            end
          rbs_pkg::ST_BOUND_FLASH:
            if (tmr_r == 13'h0000)
            begin
              state_r <= rbs_pkg::ST_POWERUP;
              tmr_r <= `RBS_AMBER_MS;
            end
          default:
            state_r <= state_r;
        endcase
    end
  end

  // Packet activity stretch so short bursts stay visible
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      pkt_r <= 8'h00;
    else if (pkt_i)
      pkt_r <= `RBS_PKT_MS;
    else if (tick_r && pkt_r != 8'h00)
      pkt_r <= pkt_r - 8'h01;
  end

  // LED patterns per state
  always_comb
  begin
    l1 = `RBS_LED_OFF;
    l2 = `RBS_LED_OFF;
    case (state_r)
      rbs_pkg::ST_POWERUP: l2 = `RBS_LED_AMB;
      rbs_pkg::ST_SEARCH: l1 = (single ? slow : fast) ? `RBS_LED_RED : `RBS_LED_OFF;
      rbs_pkg::ST_DETECT: l1 = `RBS_LED_RED;
      rbs_pkg::ST_CHOSEN: l2 = `RBS_LED_AMB;
      rbs_pkg::ST_SYNCING: l2 = `RBS_LED_RED;
      rbs_pkg::ST_SYNCED: l1 = fast ? `RBS_LED_GRN : `RBS_LED_OFF;
      rbs_pkg::ST_RUN_SOLID: l1 = `RBS_LED_GRN;
      rbs_pkg::ST_RUN:
      begin
        l1 = fast ? `RBS_LED_GRN : `RBS_LED_OFF;
        l2 = (pkt_r != 8'h00 && ms_r[`RBS_PKT_BIT]) ? `RBS_LED_AMB : `RBS_LED_OFF;
      end
      rbs_pkg::ST_BIND:
        if (coord && single)
          l1 = fast ? `RBS_LED_RED : `RBS_LED_GRN;
        else if (coord)
        begin
          l1 = fast ? `RBS_LED_RED : `RBS_LED_OFF;
          l2 = l1;
        end
        else
        begin
          l1 = fast ? `RBS_LED_RED : `RBS_LED_OFF;
          l2 = fast ? `RBS_LED_OFF : `RBS_LED_RED;
        end
      rbs_pkg::ST_BOUND_HOLD:
      begin
        l1 = `RBS_LED_RED;
        l2 = `RBS_LED_RED;
      end
      rbs_pkg::ST_BOUND_FLASH:
      begin
        l1 = tmr_r[`RBS_FAST_BIT] ? `RBS_LED_RED : `RBS_LED_OFF;
        l2 = l1;
      end
      default:
        l1 = `RBS_LED_OFF;
    endcase
  end

  // Slot budget from the selector; user value for the first code
  always_comb
  begin
    case (ctrl_r[`RBS_CTRL_SLOT_HI:`RBS_CTRL_SLOT_LO])
      2'h0: budget = ctrl_r[`RBS_CTRL_USER_HI:`RBS_CTRL_USER_LO];
      2'h1: budget = `RBS_SLOT_32;
      2'h2: budget = `RBS_SLOT_FRAME;
      default: budget = `RBS_SLOT_4;
    endcase
  end

  // Slot position within each 128 slot frame
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      slot_r <= 7'h00;
    else if (slot_tick_i)
      slot_r <= slot_r + 7'h01;
  end

  // Registered outputs; serial disable gates only the serial port
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      form_net_o <= 1'b0;
      sync_req_o <= 1'b0;
      tx_allow_o <= 1'b0;
      frame_ms_o <= `RBS_FRAME_OFF_MS;
      serial_en_o <= 1'b1;
      led1_o <= `RBS_LED_OFF;
      led2_o <= `RBS_LED_OFF;
    end
    else
    begin
      form_net_o <= state_r != rbs_pkg::ST_BIND && state_r != rbs_pkg::ST_BOUND_HOLD &&
                    state_r != rbs_pkg::ST_BOUND_FLASH;
      sync_req_o <= (state_r == rbs_pkg::ST_SYNCING);
      tx_allow_o <= coord || ({1'b0, slot_r} < budget);
      frame_ms_o <= ctrl_r[`RBS_CTRL_FRAME] ? `RBS_FRAME_ON_MS : `RBS_FRAME_OFF_MS;
      serial_en_o <= !ctrl_r[`RBS_CTRL_SER_DIS];
      // Single LED units merge both patterns onto the first LED
      led1_o <= single ? (l1 | l2) : l1;
      led2_o <= single ? `RBS_LED_OFF : l2;
    end
  end

  // Poll relay filter; local IDs stay on the wire
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      relay_valid_o <= 1'b0;
      relay_id_o <= 8'h00;
      drop_cnt_r <= 8'h00;
    end
    else
    begin
      relay_valid_o <= poll_valid_i && poll_id_i > `RBS_LOCAL_ID_MAX;
      if (poll_valid_i)
        relay_id_o <= poll_id_i;
      if (poll_valid_i && poll_id_i <= `RBS_LOCAL_ID_MAX && drop_cnt_r != 8'hFF)
        drop_cnt_r <= drop_cnt_r + 8'h01;
    end
  end

  // AXI4-Lite write path; address and data taken in either order
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 32'h0000_0000;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RBS_RESP_OKAY;
      ctrl_r <= `RBS_CTRL_RST;
      node_id_r <= `RBS_NODE_ID_RST;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (aw_held_r && w_held_r && !s_axi_bvalid)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `RBS_RESP_OKAY;
        if (awaddr_r == `RBS_CTRL_OFF)
        begin
          if (wstrb_r[0])
            ctrl_r[7:0] <= wdata_r[7:0];
          if (wstrb_r[1])
            ctrl_r[15:8] <= wdata_r[15:8];
        end
        else if (awaddr_r == `RBS_NODE_ID_OFF)
        begin
          if (wstrb_r[0])
            node_id_r <= wdata_r[7:0];
        end
        else if (awaddr_r == `RBS_STATUS_OFF || awaddr_r == `RBS_DROP_OFF)
          s_axi_bresp <= `RBS_RESP_OKAY; // Read-only: write ignored
        else
          s_axi_bresp <= `RBS_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // AXI4-Lite read path; one read at a time
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RBS_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `RBS_RESP_OKAY;
      if (s_axi_araddr == `RBS_CTRL_OFF)
        s_axi_rdata <= {16'h0000, ctrl_r};
      else if (s_axi_araddr == `RBS_STATUS_OFF)
        // ID range flag helps software keep radio IDs legal
        s_axi_rdata <= {24'h000000, node_id_r >= `RBS_RADIO_ID_MIN && node_id_r <= `RBS_RADIO_ID_MAX,
                        tx_allow_o, form_net_o, state_r == rbs_pkg::ST_BIND, state_r};
      else if (s_axi_araddr == `RBS_NODE_ID_OFF)
        s_axi_rdata <= {24'h000000, node_id_r};
      else if (s_axi_araddr == `RBS_DROP_OFF)
        s_axi_rdata <= {24'h000000, drop_cnt_r};
      else
      begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `RBS_RESP_SLVERR;
      end
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  sequence s_bind_code;
    state_r == rbs_pkg::ST_BIND && !coord && bind_code_i && !tri_click;
  endsequence
  sequence s_hold_red;
    (led1_o == `RBS_LED_RED && led2_o == `RBS_LED_RED) [*2];
  endsequence

  property p_serial_radio;
    ($rose(ctrl_r[`RBS_CTRL_SER_DIS]) && $stable(state_r)) |=> !serial_en_o && form_net_o == $past(form_net_o);
  endproperty
  a_serial_radio: assert property (p_serial_radio) else $error("serial disable disturbed radio");
  property p_slot_budget;
    (!coord && {1'b0, slot_r} >= budget && $stable(ctrl_r)) |=> !tx_allow_o;
  endproperty
  a_slot_budget: assert property (p_slot_budget) else $error("transmit outside slot budget");
  property p_frame;
    ##1 (frame_ms_o == ($past(ctrl_r[`RBS_CTRL_FRAME]) ? 8'h28 : 8'h3C));
  endproperty
  a_frame: assert property (p_frame) else $error("wrong frame length");
  property p_local_poll;
    (poll_valid_i && poll_id_i <= 8'h0A) |=> !relay_valid_o;
  endproperty
  a_local_poll: assert property (p_local_poll) else $error("local poll relayed");
  property p_bind_exit;
    s_bind_code |=> state_r == rbs_pkg::ST_BOUND_HOLD && tmr_r == 13'h0FA0;
  endproperty
  a_bind_exit: assert property (p_bind_exit) else $error("child stayed in binding");
  property p_hold_leds;
    (s_bind_code ##1 !single) |=> s_hold_red;
  endproperty
  a_hold_leds: assert property (p_hold_leds) else $error("bound LEDs not solid red");
  property p_no_form;
    state_r == rbs_pkg::ST_BIND |=> !form_net_o;
  endproperty
  a_no_form: assert property (p_no_form) else $error("forming during binding");
  property p_coord_bind_led;
    (state_r == rbs_pkg::ST_BIND && coord && !single) |=> led1_o == led2_o && led1_o[1] == 1'b0;
  endproperty
  a_coord_bind_led: assert property (p_coord_bind_led) else $error("coordinator bind LEDs wrong");
  property p_sync_order;
    $rose(sync_req_o) |-> $past(state_r == rbs_pkg::ST_CHOSEN, 2) && $past(parent_ready_i, 2);
  endproperty
  a_sync_order: assert property (p_sync_order) else $error("sync before parent ready");
endmodule : rbs_top

// file: tb/rbs_net_model.sv
// Network layer stand-in: slot ticks and sync answers
`timescale 1ns/1ps
module rbs_net_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Request from the sequencer
  input wire logic sync_req_i,
  // Events to the sequencer
  output logic slot_tick_o,
  output logic sync_done_o
);
  // Slot divider, one tick every four cycles
  logic [1:0] div_r;
  // Sync delay, slow so the request is seen holding
  logic [3:0] wait_r;
  // Free-running slot ticks
  always_ff @(posedge clk_i)
  begin
    div_r <= srst_i ? 2'h0 : div_r + 2'h1;
    slot_tick_o <= !srst_i && (div_r == 2'h3);
  end
  // Answer only while asked, never unprompted
  always_ff @(posedge clk_i)
  begin
    wait_r <= (srst_i || !sync_req_i) ? 4'h0 : wait_r + {3'h0, wait_r != 4'hF};
    sync_done_o <= sync_req_i && (wait_r == 4'hE);
  end
endmodule : rbs_net_model

// file: tb/tb_rbs_top.sv
// Self-checking bench of the bind and status sequencer
`timescale 1ns/1ps
module tb_rbs_top;
  // Short ms tick keeps long indicator times brief
  localparam int unsigned TCK = 4;
  // Bus side
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  // Operator and network side
  logic btn_i = 1'b0;
  logic poll_valid_i = 1'b0;
  logic [7:0] poll_id_i = 8'h00;
  logic [5:0] ev_r = 6'h00;
  logic slot_tick_i, sync_done_i;
  wire parent_seen_i = ev_r[0];
  wire parent_chosen_i = ev_r[1];
  wire parent_ready_i = ev_r[2];
  wire run_i = ev_r[3];
  wire bind_code_i = ev_r[4];
  wire pkt_i = ev_r[5];
  logic form_net_o, sync_req_o, tx_allow_o, serial_en_o, relay_valid_o;
  logic [7:0] frame_ms_o, relay_id_o;
  logic [1:0] led1_o, led2_o;
  // Bookkeeping
  int err_total = 0;
  int n_checks = 0;
  logic [16:0] seed_r = 17'h1275A;
  logic [31:0] d;
  logic [1:0] r;
  logic [7:0] id;
  int n, drops;

  always #4 clk_i = ~clk_i;

  rbs_net_model i_rbs_net_model (.clk_i(clk_i), .srst_i(srst_i), .sync_req_i(sync_req_o),
    .slot_tick_o(slot_tick_i), .sync_done_o(sync_done_i));
  rbs_top #(.TICK_CYC(TCK)) i_rbs_top (
    .clk_i(clk_i), .srst_i(srst_i),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .btn_i(btn_i),
    .parent_seen_i(parent_seen_i), .parent_chosen_i(parent_chosen_i), .parent_ready_i(parent_ready_i),
    .sync_done_i(sync_done_i), .run_i(run_i), .pkt_i(pkt_i), .bind_code_i(bind_code_i),
    .slot_tick_i(slot_tick_i), .poll_valid_i(poll_valid_i), .poll_id_i(poll_id_i),
    .form_net_o(form_net_o), .sync_req_o(sync_req_o), .tx_allow_o(tx_allow_o), .frame_ms_o(frame_ms_o),
    .serial_en_o(serial_en_o), .relay_valid_o(relay_valid_o), .relay_id_o(relay_id_o),
    .led1_o(led1_o), .led2_o(led2_o)
  );

  // Fibonacci step, taps 17 and 14
  function automatic logic [16:0] lfsr_next(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction : lfsr_next

  // Four-state compare, counted
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  // Write: each channel released at its own handshake
  task automatic axw(input logic [31:0] a, input logic [31:0] v);
    logic pa, pw;
    pa = 1'b1;
    pw = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (pa || pw)
    begin
      @(posedge clk_i);
      pa = pa && !s_axi_awready;
      pw = pw && !s_axi_wready;
      s_axi_awvalid <= pa;
      s_axi_wvalid <= pw;
    end
    do @(posedge clk_i); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clk_i);
  endtask : axw

  // Read: data taken at the rvalid edge
  task automatic axr(input logic [31:0] a, output logic [31:0] v, output logic [1:0] rs);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk_i); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk_i); while (!s_axi_rvalid);
    v = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk_i);
  endtask : axr

  // Poll the state field until it matches, bounded
  task automatic st(input logic [3:0] x);
    int k;
    k = 0;
    do
    begin
      axr(32'h4, d, r);
      k++;
    end
    while (d[3:0] !== x && k < 9000);
    chk("state", {28'h0, x}, {28'h0, d[3:0]});
  endtask : st

  // One-cycle network event, outputs settle two edges on
  task automatic pulse(input int k);
    ev_r[k] <= 1'b1;
    @(posedge clk_i);
    ev_r[k] <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
  endtask : pulse

  // Presses three ticks long, gaps three ticks long
  task automatic clicks(input int c);
    repeat (c)
    begin
      btn_i <= 1'b1;
      repeat (3 * TCK) @(posedge clk_i);
      btn_i <= 1'b0;
      repeat (3 * TCK) @(posedge clk_i);
    end
  endtask : clicks

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict

  // Watchdog, about twice the expected run
  initial
  begin
    #(60000 * 8);
    err_total++;
    print_verdict();
  end

  initial
  begin
    repeat (10) @(posedge clk_i);
    srst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    chk("frame", 32'h3C, {24'h0, frame_ms_o});
    chk("serial", 32'h1, {31'h0, serial_en_o});
    chk("led2", 32'h3, {30'h0, led2_o});
    // Child, 40 ms frame, serial off, four slots
    axw(32'h0, 32'h3C);
    chk("bresp", 32'h0, {30'h0, r});
    axw(32'h10, 32'hFF);
    chk("bresp", 32'h2, {30'h0, r});
    axr(32'h0, d, r);
    chk("ctrl", 32'h3C, d);
    chk("frame", 32'h28, {24'h0, frame_ms_o});
    chk("serial", 32'h0, {31'h0, serial_en_o});
    axr(32'h10, d, r);
    chk("resp", 32'h2, {30'h0, r});
    $display("test config done");
    n = 0;
    repeat (128)
    begin
      do @(posedge clk_i); while (!slot_tick_i);
      n += int'(tx_allow_o === 1'b1);
    end
    chk("slots", 32'd4, n);
    $display("test slots done");
    drops = 0;
    for (int i = 0; i < 24; i++)
    begin
      seed_r = lfsr_next(seed_r);
      id = (i == 0) ? 8'h0A : (i == 1) ? 8'h0B : {2'h0, seed_r[5:0]};
      poll_id_i <= id;
      poll_valid_i <= 1'b1;
      @(posedge clk_i);
      poll_valid_i <= 1'b0;
      #1;
      chk("relay", {31'h0, id > 8'h0A}, {31'h0, relay_valid_o});
      chk("relay_id", {24'h0, id}, {24'h0, relay_id_o});
      drops += int'(id <= 8'h0A);
      @(posedge clk_i);
    end
    axr(32'hC, d, r);
    chk("drops", drops, d);
    axw(32'h8, 32'h3C);
    axr(32'h4, d, r);
    chk("id_ok", 32'h1, {31'h0, d[7]});
    $display("test polls done");
    // Child join sequence, serial still off
    st(4'h1);
    pulse(0);
    chk("led1", 32'h1, {30'h0, led1_o});
    pulse(1);
    chk("led2", 32'h3, {30'h0, led2_o});
    pulse(2);
    chk("led2", 32'h1, {30'h0, led2_o});
    chk("sync", 32'h1, {31'h0, sync_req_o});
    st(4'h5);
    pulse(3);
    chk("led1", 32'h2, {30'h0, led1_o});
    $display("test join done");
    // Child binding
    clicks(3);
    st(4'h8);
    chk("form", 32'h0, {31'h0, form_net_o});
    pulse(4);
    st(4'h9);
    chk("led1", 32'h1, {30'h0, led1_o});
    chk("led2", 32'h1, {30'h0, led2_o});
    repeat (15000) @(posedge clk_i);
    st(4'h9);
    st(4'hA);
    $display("test child bind done");
    // Coordinator binding and exit
    axw(32'h0, 32'h1);
    st(4'h7);
    clicks(3);
    st(4'h8);
    chk("bindled", 32'h0, {30'h0, led1_o ^ led2_o});
    clicks(2);
    st(4'h7);
    chk("form", 32'h1, {31'h0, form_net_o});
    pulse(5);
    chk("tx", 32'h1, {31'h0, tx_allow_o});
    n = 0;
    repeat (300)
    begin
      @(posedge clk_i);
      n += int'(led2_o === 2'h3);
    end
    chk("pktled", 32'h1, {31'h0, n > 0});
    axw(32'h0, 32'h3);
    chk("led2", 32'h0, {30'h0, led2_o});
    $display("test coordinator done");
    print_verdict();
  end
endmodule : tb_rbs_top
